// ### design/srp_spi_rx_map.svh
// Purpose: Offsets, field positions and reset values of the serial receive block
// Assumes: Byte addresses on the register bus, one 32-bit word per register
// Notes: Definitions only
`ifndef SRP_SPI_RX_MAP_SVH
`define SRP_SPI_RX_MAP_SVH

`define SRP_OFF_CR1 8'h00
`define SRP_OFF_CR2 8'h04
`define SRP_OFF_SR 8'h08
`define SRP_OFF_DR 8'h0C
`define SRP_OFF_NUM 8'h10
`define SRP_OFF_POLY 8'h14
`define SRP_OFF_RXCRC 8'h18
`define SRP_OFF_TXCRC 8'h1C
`define SRP_OFF_PAD 8'h50

`define SRP_CR1_SPE 11
`define SRP_CR1_SSN 10
`define SRP_CR1_RECEIVE_ONLY_ENABLE 7
`define SRP_CR1_CRC_ENABLE 5
`define SRP_CR1_CRCL 4
`define SRP_CR1_MSTR 3
`define SRP_CR1_LSB 2
`define SRP_CR1_CPOL 1
`define SRP_CR1_CPHA 0

`define SRP_CR2_RXDMA 10
`define SRP_CR2_TXDMA 11
`define SRP_CR2_ERROR_IRQ_ENABLE 9
`define SRP_CR2_TRANSMIT_IRQ_ENABLE 8
`define SRP_CR2_RECEIVE_IRQ_ENABLE 7

`define SRP_SR_OVR 8
`define SRP_SR_CRC_MISMATCH_FLAG 7

`define SRP_RST_CR1 12'h400
`define SRP_RST_CR2 12'h007
`define SRP_RST_PAD 9'h000
`define SRP_QUEUE_DEPTH 2'h2

`endif

// ### design/srp_pkg.sv
// Purpose: Types shared by the serial receive block
// Assumes: Nothing beyond SystemVerilog
// Notes: Constants live in srp_spi_rx_map.svh
package srp_pkg;
  typedef enum logic {SRP_DATA, SRP_CRC} srp_phase_t;
endpackage

// ### design/srp_spi_rx.sv
// Purpose: Receive side of a serial peripheral with Wishbone register access
// Assumes: Link pins are asynchronous to ref_clk and much slower than it
// Notes: Master clock comes from a divider of ref_clk; slave clock is sampled
//
// The Wishbone slave port was decided locally.
`include "srp_spi_rx_map.svh"
`timescale 1ns/1ns
`default_nettype none

module srp_spi_rx #(
  parameter int CNT_W = 16
) (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic sclk_in,
  input wire logic cs_in_n,
  input wire logic sdi,
  output logic sclk_out,
  output logic sclk_oe,
  output logic cs_out_n,
  output logic sdo,
  output logic irq,
  output logic rx_dma_req,
  output logic tx_dma_req,
  output logic [8:0] pad_fast_select
);

  function automatic logic [5:0] ds_bits(input logic [3:0] ds);
    if (ds == 4'h0 || ds == 4'h1) return 6'h08;
    if (ds == 4'h2) return 6'h20;
    return {2'h0, ds} + 6'h01;
  endfunction

  function automatic logic [6:0] half_div(input logic [2:0] br);
    case (br)
      3'h0: return 7'h02;
      3'h1: return 7'h03;
      3'h2: return 7'h04;
      3'h3: return 7'h06;
      3'h4: return 7'h0C;
      3'h5: return 7'h18;
      3'h6: return 7'h30;
      default: return 7'h60;
    endcase
  endfunction

  function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic b,
                                           input logic [15:0] poly, input logic len16);
    logic fb;
    logic [15:0] nxt;
    fb = (len16 ? crc[15] : crc[7]) ^ b;
    nxt = {crc[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
    return len16 ? nxt : {8'h00, nxt[7:0]};
  endfunction

  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  logic rst_s1, rst_n;
  logic [2:0] pin_s1, pin_s2;
  logic [11:0] cr1, cr2;
  logic [CNT_W-1:0] num, word_cnt;
  logic [15:0] poly, rx_crc, tx_crc, crc_calc, tx_crc_calc;
  logic [31:0] rxq [2];
  logic [31:0] txq [2];
  logic [31:0] last_rd, rx_sh, tx_sh, rd_mux, wr_word, dr_val, new_sh, asm_word;
  logic [1:0] rx_cnt, tx_cnt, next_rx_cnt, next_tx_cnt;
  logic rx_head, tx_head, overflow_flag, crc_mismatch_flag, tx_loaded, lvl_prev, sclk_q;
  logic [5:0] bit_cnt, word_bits, frame_bits;
  logic [6:0] div_cnt;
  srp_pkg::srp_phase_t phase;

  // Reset release and pin synchronisers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_s1 <= 1'b0;
      rst_n <= 1'b0;
      pin_s1 <= 3'h2;
      pin_s2 <= 3'h2;
    end else begin
      rst_s1 <= 1'b1;
      rst_n <= rst_s1;
      pin_s1 <= {sclk_in, cs_in_n, sdi};
      pin_s2 <= pin_s1;
    end
  end

  wire spe = cr1[`SRP_CR1_SPE];
  wire mstr = cr1[`SRP_CR1_MSTR];
  wire receive_only_enable = cr1[`SRP_CR1_RECEIVE_ONLY_ENABLE];
  wire crc_enable = cr1[`SRP_CR1_CRC_ENABLE];
  wire crcl = cr1[`SRP_CR1_CRCL];
  wire lsb = cr1[`SRP_CR1_LSB];
  wire cpol = cr1[`SRP_CR1_CPOL];
  wire cpha = cr1[`SRP_CR1_CPHA];
  wire cs_s2 = pin_s2[1];
  wire bit_in = pin_s2[0];
  wire in_crc = phase == srp_pkg::SRP_CRC;

  // Bus decode
  wire acc = wb_cyc_i & wb_stb_i;
  wire fire = acc & wb_ack_o;
  wire wr_fire = fire & wb_we_i;
  wire rd_fire = fire & ~wb_we_i;
  wire sel_cr1 = wb_adr_i == `SRP_OFF_CR1;
  wire sel_cr2 = wb_adr_i == `SRP_OFF_CR2;
  wire sel_sr = wb_adr_i == `SRP_OFF_SR;
  wire sel_dr = wb_adr_i == `SRP_OFF_DR;
  wire sel_num = wb_adr_i == `SRP_OFF_NUM;
  wire sel_poly = wb_adr_i == `SRP_OFF_POLY;
  wire sel_rxc = wb_adr_i == `SRP_OFF_RXCRC;
  wire sel_txc = wb_adr_i == `SRP_OFF_TXCRC;
  wire sel_pad = wb_adr_i == `SRP_OFF_PAD;
  wire dr_rd = rd_fire & sel_dr;
  wire dr_wr = wr_fire & sel_dr;
  wire sr_wr = wr_fire & sel_sr;

  // Link timing
  wire lvl = mstr ? sclk_q : pin_s2[2];
  wire link_act = mstr | ~cs_s2;
  wire sample = spe & link_act & (lvl != lvl_prev) & (lvl == (cpol ^ ~cpha));
  assign word_bits = ds_bits(cr2[3:0]);
  assign frame_bits = in_crc ? (crcl ? 6'h10 : 6'h08) : word_bits;
  wire word_done = sample & (bit_cnt == 6'(frame_bits - 6'h01));
  wire counting = crc_enable | receive_only_enable;
  wire last_word = word_cnt == CNT_W'(num - 1'b1);
  wire batch_end = word_done & ~in_crc & counting & last_word;
  wire crc_done = word_done & in_crc;
  wire m_run = spe & mstr & ~cr1[`SRP_CR1_SSN]
             & ((receive_only_enable & (num != '0)) | tx_loaded | (bit_cnt != 6'h00) | in_crc);
  wire busy = spe & (mstr ? (m_run | (sclk_q != cpol)) : ~cs_s2);

  assign new_sh = lsb ? {bit_in, rx_sh[31:1]} : {rx_sh[30:0], bit_in};
  assign asm_word = lsb ? (new_sh >> (6'h20 - frame_bits)) : new_sh;
  wire crc_bad = crc_done & (asm_word[15:0] != crc_calc);

  // Queues
  wire rx_push_ok = word_done & (rx_cnt != `SRP_QUEUE_DEPTH);
  wire rx_pop = dr_rd & (rx_cnt != 2'h0);
  wire rx_tail = rx_head ^ rx_cnt[0];
  wire tx_push_ok = dr_wr & (tx_cnt != `SRP_QUEUE_DEPTH);
  // An idle slave keeps its words queued; popping while deselected would drop them
  wire tx_pop = spe & link_act & ~in_crc & ~receive_only_enable & ~tx_loaded & (bit_cnt == 6'h00) & (tx_cnt != 2'h0);
  wire tx_tail = tx_head ^ tx_cnt[0];
  wire ovr_set = (word_done & ~rx_push_ok) | (dr_wr & ~tx_push_ok);
  assign next_rx_cnt = rx_cnt + {1'b0, rx_push_ok} - {1'b0, rx_pop};
  assign next_tx_cnt = tx_cnt + {1'b0, tx_push_ok} - {1'b0, tx_pop};
  wire receive_not_empty_flag = rx_cnt != 2'h0;
  wire transmit_not_full_flag = tx_cnt != `SRP_QUEUE_DEPTH;
  assign dr_val = receive_not_empty_flag ? rxq[rx_head] : last_rd;

  wire [8:0] sr = {overflow_flag, crc_mismatch_flag, busy, tx_cnt, rx_cnt, transmit_not_full_flag, receive_not_empty_flag};
  assign rd_mux = sel_cr1 ? {20'h0, cr1}
                : sel_cr2 ? {20'h0, cr2}
                : sel_sr ? {23'h0, sr}
                : sel_dr ? dr_val
                : sel_num ? 32'(num)
                : sel_poly ? {16'h0, poly}
                : sel_rxc ? {16'h0, rx_crc}
                : sel_txc ? {16'h0, tx_crc}
                : sel_pad ? {23'h0, pad_fast_select}
                : 32'h0;
  assign wr_word = wmerge(rd_mux, wb_dat_i, wb_sel_i);

  // Register file and bus answer
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      cr1 <= `SRP_RST_CR1;
      cr2 <= `SRP_RST_CR2;
      num <= '0;
      poly <= 16'h0;
      pad_fast_select <= `SRP_RST_PAD;
    end else if (clk_en) begin
      wb_ack_o <= acc & ~wb_ack_o;
      if (acc & ~wb_ack_o) wb_dat_o <= rd_mux;
      if (batch_end & ~crc_enable) cr1[`SRP_CR1_RECEIVE_ONLY_ENABLE] <= 1'b0;
      if (crc_done) begin
        cr1[`SRP_CR1_RECEIVE_ONLY_ENABLE] <= 1'b0;
        cr1[`SRP_CR1_CRC_ENABLE] <= 1'b0;
      end
      // A software write in the same cycle wins so a new batch is never lost
      if (wr_fire & sel_cr1) cr1 <= wr_word[11:0];
      if (wr_fire & sel_cr2) cr2 <= wr_word[11:0];
      if (wr_fire & sel_num) num <= wr_word[CNT_W-1:0];
      if (wr_fire & sel_poly) poly <= wr_word[15:0];
      if (wr_fire & sel_pad) pad_fast_select <= wr_word[8:0];
    end
  end

  // Queue storage and sticky flags
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_cnt <= 2'h0;
      rx_head <= 1'b0;
      tx_cnt <= 2'h0;
      tx_head <= 1'b0;
      rxq <= '{default: 32'h0};
      txq <= '{default: 32'h0};
      last_rd <= 32'h0;
      overflow_flag <= 1'b0;
      crc_mismatch_flag <= 1'b0;
    end else if (clk_en) begin
      if (!spe) begin
        rx_cnt <= 2'h0;
        rx_head <= 1'b0;
        tx_cnt <= 2'h0;
        tx_head <= 1'b0;
      end else begin
        if (rx_push_ok) rxq[rx_tail] <= in_crc ? asm_word : asm_word;
        rx_cnt <= next_rx_cnt;
        rx_head <= rx_head ^ rx_pop;
        if (tx_push_ok) txq[tx_tail] <= wb_dat_i;
        tx_cnt <= next_tx_cnt;
        tx_head <= tx_head ^ tx_pop;
      end
      if (rx_pop) last_rd <= rxq[rx_head];
      // Set beats a clearing write in the same cycle
      if (ovr_set) overflow_flag <= 1'b1;
      else if (sr_wr & ~wr_word[`SRP_SR_OVR]) overflow_flag <= 1'b0;
      if (crc_bad) crc_mismatch_flag <= 1'b1;
      else if (sr_wr & ~wr_word[`SRP_SR_CRC_MISMATCH_FLAG]) crc_mismatch_flag <= 1'b0;
    end
  end

  // Shift engine, batch counting and CRC
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_sh <= 32'h0;
      tx_sh <= 32'h0;
      tx_loaded <= 1'b0;
      bit_cnt <= 6'h00;
      word_cnt <= '0;
      phase <= srp_pkg::SRP_DATA;
      crc_calc <= 16'h0;
      tx_crc_calc <= 16'h0;
      rx_crc <= 16'h0;
      tx_crc <= 16'h0;
      lvl_prev <= 1'b0;
    end else if (clk_en) begin
      lvl_prev <= lvl;
      if (!spe || (!mstr && cs_s2)) begin
        rx_sh <= 32'h0;
        bit_cnt <= 6'h00;
        tx_loaded <= 1'b0;
        if (!spe) begin
          word_cnt <= '0;
          phase <= srp_pkg::SRP_DATA;
          crc_calc <= 16'h0;
          tx_crc_calc <= 16'h0;
        end
      end else begin
        if (tx_pop) begin
          tx_sh <= txq[tx_head];
          tx_loaded <= 1'b1;
        end
        if (sample) begin
          rx_sh <= word_done ? 32'h0 : new_sh;
          bit_cnt <= word_done ? 6'h00 : bit_cnt + 6'h01;
          tx_sh <= lsb ? (tx_sh >> 1) : (tx_sh << 1);
          if (crc_enable && !in_crc) begin
            crc_calc <= crc_step(crc_calc, bit_in, poly, crcl);
            tx_crc_calc <= crc_step(tx_crc_calc, sdo, poly, crcl);
          end
        end
        if (word_done) tx_loaded <= 1'b0;
        if (word_done && !in_crc && counting) word_cnt <= last_word ? '0 : word_cnt + 1'b1;
        case (phase)
          srp_pkg::SRP_DATA: begin
            if (batch_end && crc_enable) phase <= srp_pkg::SRP_CRC;
          end
          srp_pkg::SRP_CRC: begin
            if (crc_done) begin
              phase <= srp_pkg::SRP_DATA;
              rx_crc <= crc_calc;
              tx_crc <= tx_crc_calc;
              crc_calc <= 16'h0;
              tx_crc_calc <= 16'h0;
            end
          end
          default: phase <= srp_pkg::SRP_DATA;
        endcase
      end
    end
  end

  // Master clock divider; finishes the half period so the line idles cleanly
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= 7'h00;
      sclk_q <= 1'b0;
    end else if (clk_en) begin
      if (m_run || (sclk_q != cpol)) begin
        if (div_cnt >= 7'(half_div(cr2[6:4]) - 7'h01)) begin
          div_cnt <= 7'h00;
          sclk_q <= ~sclk_q;
        end else begin
          div_cnt <= div_cnt + 7'h01;
        end
      end else begin
        div_cnt <= 7'h00;
        sclk_q <= cpol;
      end
    end
  end

  assign sclk_out = sclk_q;
  assign sclk_oe = spe & mstr;
  assign cs_out_n = cr1[`SRP_CR1_SSN] | ~spe;
  assign sdo = lsb ? tx_sh[0] : tx_sh[5'(word_bits - 6'h01)];
  assign irq = (cr2[`SRP_CR2_ERROR_IRQ_ENABLE] & (overflow_flag | crc_mismatch_flag))
             | (cr2[`SRP_CR2_RECEIVE_IRQ_ENABLE] & receive_not_empty_flag)
             | (cr2[`SRP_CR2_TRANSMIT_IRQ_ENABLE] & transmit_not_full_flag & spe);
  assign rx_dma_req = spe & cr2[`SRP_CR2_RXDMA] & receive_not_empty_flag;
  assign tx_dma_req = spe & cr2[`SRP_CR2_TXDMA] & transmit_not_full_flag;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_crc_end;
    clk_en && crc_done;
  endsequence

  a_overflow_rx: assert property (clk_en && word_done && rx_cnt == 2'h2 |=> overflow_flag && rx_cnt == 2'h2)
    else $error("word into full queue did not flag overflow");
  a_queue_flush: assert property (clk_en && !spe |=> rx_cnt == 2'h0 && tx_cnt == 2'h0)
    else $error("queue not flushed when disabled");
  a_empty_read: assert property (clk_en && dr_rd && rx_cnt == 2'h0 && !word_done
                                 |=> rx_cnt == 2'h0 && $stable(last_rd))
    else $error("empty data read changed the queue");
  a_pop_oldest: assert property (clk_en && rx_pop && !word_done |=> rx_cnt == $past(rx_cnt) - 2'h1
                                 && last_rd == $past(rxq[rx_head]))
    else $error("data read did not pop oldest word");
  a_receive_only_enable_done: assert property (clk_en && batch_end && !crc_enable && !(wr_fire && sel_cr1)
                                  |=> !receive_only_enable)
    else $error("receive-only not cleared at batch end");
  a_crc_finish: assert property (s_crc_end ##0 !(wr_fire && sel_cr1) |=> !crc_enable && rx_crc == $past(crc_calc))
    else $error("CRC batch end not handled");
  a_crc_sticky: assert property (clk_en && crc_bad |=> crc_mismatch_flag ##1 (crc_mismatch_flag || $past(sr_wr)))
    else $error("CRC error flag not held");
  a_slave_busy: assert property (spe && !mstr |-> sr[6] == !cs_s2)
    else $error("slave busy does not follow chip select");
  a_tx_overflow: assert property (clk_en && dr_wr && tx_cnt == 2'h2 |=> overflow_flag)
    else $error("write into full transmit queue missed overflow");
  a_err_irq: assert property (clk_en && ovr_set && cr2[`SRP_CR2_ERROR_IRQ_ENABLE] |=> irq)
    else $error("error interrupt missing");

endmodule // srp_spi_rx
`default_nettype wire

// ### sim/srp_spi_master_model.sv
// Purpose: External serial master that feeds the receive path in slave mode
// Assumes: Clock polarity 0, phase 0, 8-bit words sent MSB first
// Notes: Link clock stands still between bursts; the data line is released after
`timescale 1ns/1ns
`default_nettype none
module srp_spi_master_model (
  output logic sclk,
  output logic cs_n,
  output logic sdi
);
  localparam int HALF_NS = 32;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // Whole burst under one low select, never pulsed between words
  task automatic frame(input logic [31:0] data, input int nbytes);
    cs_n = 1'b0;
    #(HALF_NS);
    for (int i = 31; i >= 32 - 8 * nbytes; i--) begin
      sdi = data[i];
      #(HALF_NS);
      sclk = 1'b1;
      #(HALF_NS);
      sclk = 1'b0;
    end
    #(HALF_NS);
    cs_n = 1'b1;
    // Released line floats; show the inverse so a stale bit is never reused
    sdi = ~sdi;
  endtask
endmodule // srp_spi_master_model
`default_nettype wire

// ### sim/testbench.sv
// Purpose: Self-checking bench for the serial receive block in slave mode
// Assumes: 8-bit words, one external master model on the link pins
// Notes: Register table first, then bursts, overflow, flush and batch end
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct packed {
    logic we;
    logic [7:0] adr;
    logic [31:0] wd;
    logic [31:0] exp;
  } srp_row_t;
  logic ref_clk;
  logic reset_n;
  logic clk_en;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic sclk_in;
  logic cs_in_n;
  logic sdi;
  logic irq;
  logic rx_dma_req;
  logic [31:0] rd;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  srp_row_t rows [8] = '{
    '{1'b0, 8'h00, 32'h0, 32'h0000_0400},
    '{1'b0, 8'h04, 32'h0, 32'h0000_0007},
    '{1'b0, 8'h08, 32'h0, 32'h0000_0002},
    '{1'b0, 8'h50, 32'h0, 32'h0000_0000},
    '{1'b1, 8'h50, 32'h0000_01FF, 32'h0},
    '{1'b0, 8'h50, 32'h0, 32'h0000_01FF},
    '{1'b1, 8'h20, 32'hFFFF_FFFF, 32'h0},
    '{1'b0, 8'h20, 32'h0, 32'h0000_0000}
  };

  srp_spi_rx uut (
    .ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .sclk_in(sclk_in), .cs_in_n(cs_in_n), .sdi(sdi),
    .sclk_out(), .sclk_oe(), .cs_out_n(), .sdo(),
    .irq(irq), .rx_dma_req(rx_dma_req), .tx_dma_req(), .pad_fast_select()
  );
  srp_spi_master_model m (
    .sclk(sclk_in),
    .cs_n(cs_in_n),
    .sdi(sdi)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Hang guard: the whole run needs about a thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Classic single cycle; waits on ack, never on a fixed count
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= wd;
    wb_sel_i <= 4'hF;
    do begin
      @(posedge ref_clk);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    if (t >= 50) begin
      n_errors++;
      $display("CHECK FAILED at %0t: no bus answer", $time);
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge ref_clk);
  endtask

  initial begin
    reset_n = 1'b0;
    clk_en = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    foreach (rows[i]) begin
      wb(rows[i].we, rows[i].adr, rows[i].wd);
      if (!rows[i].we) check(rd, rows[i].exp);
    end
    // Three words into a two-entry queue, status read mid-burst
    wb(1'b1, 8'h04, 32'h0000_0487);
    wb(1'b1, 8'h00, 32'h0000_0800);
    fork
      m.frame(32'hA53C_9600, 3);
      begin
        #700;
        wb(1'b0, 8'h08, 32'h0);
        check(rd, 32'h0000_0047);
        check({31'h0, irq}, 32'h1);
        check({31'h0, rx_dma_req}, 32'h1);
      end
    join
    repeat (20) @(posedge ref_clk);
    wb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0000_010B);
    wb(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h0000_00A5);
    wb(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h0000_003C);
    wb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0000_0102);
    wb(1'b0, 8'h0C, 32'h0);
    check(rd, 32'h0000_003C);
    check({31'h0, irq}, 32'h0);
    wb(1'b1, 8'h04, 32'h0000_0207);
    check({31'h0, irq}, 32'h1);
    wb(1'b1, 8'h08, 32'h0);
    wb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0000_0002);
    check({31'h0, irq}, 32'h0);
    // Disabling the peripheral must empty the queue
    m.frame(32'h5A00_0000, 1);
    repeat (20) @(posedge ref_clk);
    wb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0000_0007);
    wb(1'b1, 8'h00, 32'h0);
    wb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0000_0002);
    // Receive-only batch of two words ends by itself
    wb(1'b1, 8'h10, 32'h0000_0002);
    wb(1'b1, 8'h00, 32'h0000_0880);
    m.frame(32'h1234_0000, 2);
    repeat (20) @(posedge ref_clk);
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0000_0800);
    wb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0000_000B);
    // Idle slave: third data write finds the transmit queue full
    wb(1'b1, 8'h0C, 32'h0000_0011);
    wb(1'b1, 8'h0C, 32'h0000_0022);
    wb(1'b1, 8'h0C, 32'h0000_0033);
    wb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0000_0129);
    check({31'h0, irq}, 32'h1);
    // Mid-run reset brings CR1, status and pad select back to their reset values
    reset_n <= 1'b0;
    repeat (3) @(posedge ref_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h0000_0400);
    wb(1'b0, 8'h08, 32'h0);
    check(rd, 32'h0000_0002);
    wb(1'b0, 8'h50, 32'h0);
    check(rd, 32'h0000_0000);
    final_report();
  end
endmodule // testbench
`default_nettype wire
